// File: psq_bus_ctrl_model.sv
`timescale 1ns/1ps
module psq_bus_ctrl_model (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic bus_request_n,
	input wire logic bus_read_strobe_n,
	input wire logic [7:0] src_value,
	input wire logic [3:0] ack_delay,
	output logic bus_ack_n,
	output logic [7:0] bus_data_in
);
	logic [3:0] wait_r;
	// ack line is pulled up, so released means high
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			wait_r <= 4'h0;
			bus_ack_n <= 1'b1;
		end else if (bus_request_n) begin
			wait_r <= 4'h0;
			bus_ack_n <= 1'b1;
		end else if (wait_r == ack_delay) begin
			bus_ack_n <= 1'b0;
		end else begin
			wait_r <= wait_r + 4'h1;
		end
	end
	// undriven bus shows the inverse so a stale capture never matches
	assign bus_data_in = bus_read_strobe_n ? ~src_value : src_value;
endmodule // psq_bus_ctrl_model

// File: psq_onehot.sv
`timescale 1ns/1ps
module psq_onehot #(
	parameter int W = 3
) (
	input wire logic [W-1:0] code,
	output logic [(1<<W)-1:0] lines
);
	always_comb begin
		lines = '0;
		lines[code] = 1'b1;
	end
endmodule // psq_onehot

// File: psq_pkg.sv
package psq_pkg;
	localparam int PSQ_AW = 8;
	localparam int PSQ_DW = 8;
	localparam int PSQ_DEPTH = 256;

	localparam logic [7:0] OP_LOAD_DATA = 8'h85;
	localparam logic [7:0] OP_LOAD_ADDR = 8'h86;
	localparam logic [7:0] OP_LOAD_LOOP = 8'h87;
	localparam logic [7:0] OP_JUMP = 8'h02;
	localparam logic [7:0] OP_DJNZ = 8'h03;
	localparam logic [7:0] OP_JUMP_HALT = 8'h04;
	localparam logic [7:0] OP_XFER = 8'h10;

	localparam logic [2:0] CMD_NONE = 3'h0;
	localparam logic [2:0] CMD_LOAD_BYTE = 3'h1;
	localparam logic [2:0] CMD_LOAD_START = 3'h2;
	localparam logic [2:0] CMD_EXECUTE = 3'h3;
	localparam logic [2:0] CMD_SWITCH = 3'h4;
	localparam logic [2:0] CMD_MASTER_SLAVE = 3'h5;
	localparam logic [2:0] CMD_PRINTER = 3'h6;

	// strobe line numbers
	localparam logic [2:0] Y_CLR_ACK = 3'h0;
	localparam logic [2:0] Y_INC_LOOP = 3'h1;
	localparam logic [2:0] Y_INC_PC = 3'h2;
	localparam logic [2:0] Y_DEMUX = 3'h3;
	localparam logic [2:0] Y_LOAD_PC = 3'h4;
	localparam logic [2:0] Y_BUS_REQ = 3'h5;
	localparam logic [2:0] Y_BAUD = 3'h6;
	localparam logic [2:0] Y_ACCESS = 3'h7;

	localparam logic [2:0] ST_0 = 3'h0;
	localparam logic [2:0] ST_1 = 3'h1;
	localparam logic [2:0] ST_2 = 3'h2;
	localparam logic [2:0] ST_3 = 3'h3;
	localparam logic [2:0] ST_4 = 3'h4;
	localparam logic [2:0] ST_FETCH = 3'h7;

	// test selects; with select-control high, 0 and 1 pick byte/execute
	localparam logic [1:0] TS_ALWAYS = 2'h0;
	localparam logic [1:0] TS_LOOP = 2'h1;
	localparam logic [1:0] TS_ACK = 2'h2;
	localparam logic [1:0] TS_BYTE = 2'h0;
	localparam logic [1:0] TS_EXEC = 2'h1;

	localparam logic [1:0] DM_PC = 2'h0;
	localparam logic [1:0] DM_DATA = 2'h1;
	localparam logic [1:0] DM_ADDR = 2'h2;
	localparam logic [1:0] DM_LOOP = 2'h3;

	localparam int BUSY_BIT = 5;
	localparam logic [7:0] LOOP_TERMINAL = 8'hff;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [7:0] CW_RESET = 8'h00;

	typedef struct packed {
		logic [1:0] tsel;
		logic [2:0] strobe;
		logic [2:0] step;
	} psq_cw_t;

	typedef struct packed {
		logic [2:0] cmd;
		logic [7:0] data;
	} psq_host_cmd_t;

	typedef struct packed {
		logic switch_buf;
		logic master_slave;
		logic printer;
	} psq_port_sel_t;

	typedef struct packed {
		logic bus_request_n;
		logic bus_read_strobe_n;
		logic addr_out_en;
		logic [7:0] addr_out;
	} psq_bus_t;
endpackage

// File: psq_port_sequencer.sv
`timescale 1ns/1ps
module psq_port_sequencer (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic sync_clear,
	input wire logic host_cmd_valid,
	input wire psq_pkg::psq_host_cmd_t host_cmd,
	input wire logic [7:0] switch_value,
	input wire logic [7:0] bus_data_in,
	input wire logic bus_ack_n,
	output psq_pkg::psq_port_sel_t port_sel,
	output logic [7:0] switch_rd_data,
	output logic [7:0] data_out,
	output logic exec_busy,
	output psq_pkg::psq_bus_t bus,
	output logic access_granted,
	output logic baud_wr_en,
	output logic [7:0] baud_wr_data
);
	import psq_pkg::*;

	typedef enum logic [6:0] {
		C_IDLE = 7'b0000001,
		C_LOAD = 7'b0000010,
		C_JUMP = 7'b0000100,
		C_HALT = 7'b0001000,
		C_DJNZ = 7'b0010000,
		C_XFER = 7'b0100000,
		C_NOP = 7'b1000000
	} psq_class_t;

	logic [7:0] mem [PSQ_DEPTH];
	logic [7:0] pc_r, pc_nxt;
	logic [7:0] ir_r, ir_nxt;
	psq_cw_t cw_r, cw_nxt;
	logic busy_r, busy_nxt;
	logic exec_req_r, exec_req_nxt;
	logic byte_loaded_r, byte_loaded_nxt;
	logic sel_ctl_r, sel_ctl_nxt;
	logic [7:0] data_buf_r, data_buf_nxt;
	logic [7:0] data_out_r, data_out_nxt;
	logic [7:0] addr_out_r, addr_out_nxt;
	logic [7:0] loop_r, loop_nxt;
	logic ack_latch_r, ack_latch_nxt;
	logic [7:0] xfer_r, xfer_nxt;
	logic [7:0] sw_rd_r, sw_rd_nxt;
	psq_port_sel_t port_sel_r, port_sel_nxt;
	logic [7:0] y;
	logic [7:0] mem_rd;
	logic mem_we;
	logic test_bit;
	logic loop_carry_n;
	logic xfer_read;
	logic [2:0] nstep;
	psq_class_t cls;

	function automatic psq_class_t class_of(input logic [7:0] op,
		input logic busy);
		if (!busy)
			return C_IDLE;
		case (op)
			OP_LOAD_DATA, OP_LOAD_ADDR, OP_LOAD_LOOP: return C_LOAD;
			OP_JUMP: return C_JUMP;
			OP_JUMP_HALT: return C_HALT;
			OP_DJNZ: return C_DJNZ;
			OP_XFER: return C_XFER;
			default: return C_NOP;
		endcase
	endfunction

	// decode ROM, word part: test select and strobe for a step
	function automatic psq_cw_t word_for(input psq_class_t c,
		input logic [2:0] s);
		psq_cw_t w;
		w.tsel = TS_ALWAYS;
		w.strobe = Y_CLR_ACK;
		w.step = s;
		if (s == ST_FETCH) begin
			w.strobe = Y_INC_PC;
		end else begin
			case (c)
				C_IDLE: begin
					case (s)
						ST_0: w.tsel = TS_BYTE;
						ST_1: w.strobe = Y_INC_PC;
						ST_2: w.tsel = TS_EXEC;
						ST_3: w.strobe = Y_LOAD_PC;
						default: w.strobe = Y_CLR_ACK;
					endcase
				end
				C_LOAD: w.strobe = (s == ST_0) ? Y_DEMUX : Y_INC_PC;
				C_JUMP, C_HALT: w.strobe = Y_LOAD_PC;
				C_DJNZ: begin
					case (s)
						ST_0: w.strobe = Y_INC_LOOP;
						ST_1: w.tsel = TS_LOOP;
						ST_2: w.strobe = Y_INC_PC;
						default: w.strobe = Y_LOAD_PC;
					endcase
				end
				C_XFER: begin
					case (s)
						ST_0: w.strobe = Y_BUS_REQ;
						ST_1: begin
							w.tsel = TS_ACK;
							w.strobe = Y_BUS_REQ;
						end
						ST_2: w.strobe = Y_ACCESS;
						ST_3: w.strobe = Y_BAUD;
						default: w.strobe = Y_CLR_ACK;
					endcase
				end
				default: w.strobe = Y_CLR_ACK;
			endcase
		end
		return w;
	endfunction

	// decode ROM, sequencing part: next step from step and test bit
	function automatic logic [2:0] next_step(input psq_class_t c,
		input logic [2:0] s, input logic t);
		if (s == ST_FETCH)
			return ST_0;
		case (c)
			C_IDLE: begin
				case (s)
					ST_0: return t ? ST_1 : ST_2;
					ST_1: return ST_2;
					ST_2: return t ? ST_3 : ST_0;
					default: return ST_FETCH;
				endcase
			end
			C_LOAD: return (s == ST_0) ? ST_1 : ST_FETCH;
			C_HALT: return ST_0;
			C_DJNZ: begin
				case (s)
					ST_0: return ST_1;
					ST_1: return t ? ST_2 : ST_3;
					default: return ST_FETCH;
				endcase
			end
			C_XFER: begin
				case (s)
					ST_0: return ST_1;
					ST_1: return t ? ST_2 : ST_1;
					ST_2: return ST_3;
					ST_3: return ST_4;
					default: return ST_FETCH;
				endcase
			end
			default: return ST_FETCH;
		endcase
	endfunction

	psq_onehot #(
		.W(3)
	) u_strobe_dec (
		.code(cw_r.strobe),
		.lines(y)
	);

	assign mem_rd = mem[pc_r];
	assign cls = class_of(ir_r, busy_r);
	assign loop_carry_n = ~(loop_r == LOOP_TERMINAL);
	assign xfer_read = (cls == C_XFER) && (cw_r.step == ST_2);

	// loading only while not busy: the strobe that advances the
	// counter is the same one that stores the byte
	assign mem_we = y[Y_INC_PC] & ~busy_r;

	always_comb begin
		case ({sel_ctl_r, cw_r.tsel})
			{1'b0, TS_ALWAYS}: test_bit = 1'b1;
			{1'b0, TS_LOOP}: test_bit = ~loop_carry_n;
			{1'b0, TS_ACK}: test_bit = ack_latch_r;
			{1'b1, TS_BYTE}: test_bit = byte_loaded_r;
			{1'b1, TS_EXEC}: test_bit = exec_req_r;
			default: test_bit = 1'b0;
		endcase
	end

	always_comb begin
		pc_nxt = pc_r;
		ir_nxt = ir_r;
		busy_nxt = busy_r;
		exec_req_nxt = exec_req_r;
		byte_loaded_nxt = byte_loaded_r;
		data_buf_nxt = data_buf_r;
		data_out_nxt = data_out_r;
		addr_out_nxt = addr_out_r;
		loop_nxt = loop_r;
		ack_latch_nxt = ack_latch_r;
		xfer_nxt = xfer_r;
		port_sel_nxt = '0;
		sw_rd_nxt = switch_value;
		sw_rd_nxt[BUSY_BIT] = busy_r;
		if (cw_r.step == ST_FETCH)
			ir_nxt = mem_rd;
		if (y[Y_INC_PC]) begin
			pc_nxt = pc_r + 8'h01;
			if (!busy_r)
				byte_loaded_nxt = 1'b0;
		end
		if (y[Y_LOAD_PC]) begin
			if (!busy_r) begin
				pc_nxt = BYTE_ZERO;
				busy_nxt = 1'b1;
				exec_req_nxt = 1'b0;
			end else begin
				pc_nxt = mem_rd;
				if (cls == C_HALT)
					busy_nxt = 1'b0;
			end
		end
		if (y[Y_DEMUX]) begin
			case (ir_r[1:0])
				DM_DATA: data_out_nxt = mem_rd;
				DM_ADDR: addr_out_nxt = mem_rd;
				DM_LOOP: loop_nxt = mem_rd;
				default: pc_nxt = mem_rd;
			endcase
		end
		if (y[Y_INC_LOOP])
			loop_nxt = loop_r + 8'h01;
		if (y[Y_CLR_ACK])
			ack_latch_nxt = 1'b0;
		// arming wins over clearing
		if (y[Y_BUS_REQ] && !bus_ack_n)
			ack_latch_nxt = 1'b1;
		if (y[Y_ACCESS])
			xfer_nxt = bus_data_in;
		if (host_cmd_valid) begin
			case (host_cmd.cmd)
				CMD_LOAD_BYTE: begin
					data_buf_nxt = host_cmd.data;
					byte_loaded_nxt = 1'b1;
				end
				CMD_LOAD_START: begin
					if (!busy_r)
						pc_nxt = BYTE_ZERO;
				end
				CMD_EXECUTE: exec_req_nxt = 1'b1;
				CMD_SWITCH: port_sel_nxt.switch_buf = 1'b1;
				CMD_MASTER_SLAVE: port_sel_nxt.master_slave = 1'b1;
				CMD_PRINTER: port_sel_nxt.printer = 1'b1;
				default: port_sel_nxt = '0;
			endcase
		end
		nstep = next_step(cls, cw_r.step, test_bit);
		cw_nxt = word_for(class_of(ir_nxt, busy_nxt), nstep);
		sel_ctl_nxt = ~busy_nxt;
		if (sync_clear) begin
			pc_nxt = BYTE_ZERO;
			ir_nxt = BYTE_ZERO;
			busy_nxt = 1'b0;
			exec_req_nxt = 1'b0;
			byte_loaded_nxt = 1'b0;
			ack_latch_nxt = 1'b0;
			sel_ctl_nxt = 1'b1;
			cw_nxt = CW_RESET;
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			pc_r <= BYTE_ZERO;
			ir_r <= BYTE_ZERO;
			cw_r <= CW_RESET;
			busy_r <= 1'b0;
			exec_req_r <= 1'b0;
			byte_loaded_r <= 1'b0;
			sel_ctl_r <= 1'b1;
			data_buf_r <= BYTE_ZERO;
			data_out_r <= BYTE_ZERO;
			addr_out_r <= BYTE_ZERO;
			loop_r <= BYTE_ZERO;
			ack_latch_r <= 1'b0;
			xfer_r <= BYTE_ZERO;
			sw_rd_r <= BYTE_ZERO;
			port_sel_r <= '0;
		end else begin
			pc_r <= pc_nxt;
			ir_r <= ir_nxt;
			cw_r <= cw_nxt;
			busy_r <= busy_nxt;
			exec_req_r <= exec_req_nxt;
			byte_loaded_r <= byte_loaded_nxt;
			sel_ctl_r <= sel_ctl_nxt;
			data_buf_r <= data_buf_nxt;
			data_out_r <= data_out_nxt;
			addr_out_r <= addr_out_nxt;
			loop_r <= loop_nxt;
			ack_latch_r <= ack_latch_nxt;
			xfer_r <= xfer_nxt;
			sw_rd_r <= sw_rd_nxt;
			port_sel_r <= port_sel_nxt;
		end
	end

	// program store has no reset; contents are whatever was loaded
	always_ff @(posedge ref_clk) begin
		if (mem_we)
			mem[pc_r] <= data_buf_r;
	end

	assign port_sel = port_sel_r;
	assign switch_rd_data = sw_rd_r;
	assign data_out = data_out_r;
	assign exec_busy = busy_r;
	assign bus.bus_request_n = ~y[Y_BUS_REQ];
	assign bus.bus_read_strobe_n = ~xfer_read;
	assign bus.addr_out_en = xfer_read;
	assign bus.addr_out = addr_out_r;
	assign access_granted = y[Y_ACCESS];
	assign baud_wr_en = y[Y_BAUD];
	assign baud_wr_data = xfer_r;
endmodule // psq_port_sequencer

// File: psq_port_sequencer_monitor.sv
`timescale 1ns/1ps
module psq_port_sequencer_monitor (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic sync_clear,
	input wire logic host_cmd_valid,
	input wire psq_pkg::psq_host_cmd_t host_cmd,
	input wire logic [7:0] switch_value,
	input wire logic [7:0] bus_data_in,
	input wire logic bus_ack_n,
	input wire psq_pkg::psq_port_sel_t port_sel,
	input wire logic [7:0] switch_rd_data,
	input wire logic exec_busy,
	input wire psq_pkg::psq_bus_t bus,
	input wire logic access_granted,
	input wire logic baud_wr_en,
	input wire logic [7:0] baud_wr_data
);
	import psq_pkg::*;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	property p_strobe_excl;
		$onehot0({!bus.bus_request_n, access_granted, baud_wr_en});
	endproperty
	a_strobe_excl: assert property (p_strobe_excl)
		else $error("control strobes overlap");
	property p_rd_en;
		bus.addr_out_en == !bus.bus_read_strobe_n;
	endproperty
	a_rd_en: assert property (p_rd_en)
		else $error("read strobe not tied to address enable");
	property p_grant_req;
		access_granted |-> !bus.bus_read_strobe_n && !$past(bus.bus_request_n);
	endproperty
	a_grant_req: assert property (p_grant_req)
		else $error("grant without prior request");
	property p_grant_baud;
		access_granted |=> baud_wr_en && baud_wr_data == $past(bus_data_in);
	endproperty
	a_grant_baud: assert property (p_grant_baud)
		else $error("transfer byte not written");
	property p_ack_grant;
		!bus.bus_request_n && !bus_ack_n |-> ##[1:3] access_granted;
	endproperty
	a_ack_grant: assert property (p_ack_grant)
		else $error("acknowledge not followed by grant");
	property p_req_hold;
		$fell(bus.bus_request_n) |-> ##1 !bus.bus_request_n;
	endproperty
	a_req_hold: assert property (p_req_hold)
		else $error("request dropped too early");
	property p_switch;
		$past(resetn) |-> switch_rd_data == {$past(switch_value[7:6]),
			$past(exec_busy), $past(switch_value[4:0])};
	endproperty
	a_switch: assert property (p_switch)
		else $error("switch read data wrong");
	property p_psel_sw;
		host_cmd_valid && host_cmd.cmd == CMD_SWITCH |=> port_sel == 3'h4;
	endproperty
	a_psel_sw: assert property (p_psel_sw)
		else $error("switch port not selected");
	property p_psel_idle;
		!host_cmd_valid |=> port_sel == 3'h0;
	endproperty
	a_psel_idle: assert property (p_psel_idle)
		else $error("port selected without command");
	property p_exec;
		host_cmd_valid && host_cmd.cmd == CMD_EXECUTE && !exec_busy
			&& !sync_clear |-> ##[1:6] exec_busy;
	endproperty
	a_exec: assert property (p_exec)
		else $error("execute did not start");
endmodule // psq_port_sequencer_monitor
bind psq_port_sequencer psq_port_sequencer_monitor
	psq_port_sequencer_monitor_inst (.ref_clk, .resetn, .sync_clear,
	.host_cmd_valid, .host_cmd, .switch_value, .bus_data_in, .bus_ack_n,
	.port_sel, .switch_rd_data, .exec_busy, .bus, .access_granted,
	.baud_wr_en, .baud_wr_data);

// File: testbench.sv
`timescale 1ns/1ps
module testbench;
	import psq_pkg::*;
	logic ref_clk, resetn, sync_clear, host_cmd_valid, bus_ack_n;
	psq_host_cmd_t host_cmd;
	logic [7:0] switch_value, bus_data_in, switch_rd_data, data_out;
	logic [7:0] baud_wr_data, seen_addr, seen_baud;
	logic [3:0] ack_delay;
	logic exec_busy, access_granted, baud_wr_en;
	psq_port_sel_t port_sel;
	psq_bus_t bus;
	int fail_count, comparisons, cycles, grants;

	psq_port_sequencer psq_port_sequencer_inst (.ref_clk, .resetn,
		.sync_clear, .host_cmd_valid, .host_cmd, .switch_value,
		.bus_data_in, .bus_ack_n, .port_sel, .switch_rd_data, .data_out,
		.exec_busy, .bus, .access_granted, .baud_wr_en, .baud_wr_data);
	psq_bus_ctrl_model psq_bus_ctrl_model_inst (.ref_clk, .resetn,
		.bus_request_n(bus.bus_request_n),
		.bus_read_strobe_n(bus.bus_read_strobe_n),
		.src_value(switch_value), .ack_delay, .bus_ack_n, .bus_data_in);

	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 60000) begin
			fail_count++;
			complete_run();
		end
	end
	// sampled mid-cycle, where the outputs have settled
	always @(negedge ref_clk) begin
		if (bus.addr_out_en) seen_addr = bus.addr_out;
		if (baud_wr_en) seen_baud = baud_wr_data;
		if (access_granted) grants++;
	end

	task automatic complete_run;
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input string what, input logic [7:0] exp,
		input logic [7:0] got);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic idle(input int n);
		repeat (n) @(negedge ref_clk);
	endtask
	task automatic cmd(input logic [2:0] c, input logic [7:0] d);
		@(negedge ref_clk);
		host_cmd_valid = 1'b1;
		host_cmd = '{cmd: c, data: d};
		@(negedge ref_clk);
		host_cmd_valid = 1'b0;
	endtask
	task automatic load(input logic [7:0] prog[$]);
		cmd(CMD_LOAD_START, 8'h00);
		idle(5);
		foreach (prog[i]) begin
			cmd(CMD_LOAD_BYTE, prog[i]);
			idle(5);
		end
	endtask
	task automatic load_run(input logic [7:0] prog[$]);
		int n;
		load(prog);
		cmd(CMD_EXECUTE, 8'h00);
		idle(8);
		n = 0;
		while (switch_rd_data[5] !== 1'b0 && n < 2000) begin
			idle(1);
			n++;
		end
		chk("busy after halt", 8'h00, {7'h0, exec_busy});
	endtask
	task automatic t_psel;
		for (int i = 0; i < 3; i++) begin
			cmd(CMD_SWITCH + 3'(i), 8'h00);
			chk("port select", 8'h4 >> i, {5'h0, port_sel});
			idle(1);
			chk("port select idle", 8'h00, {5'h0, port_sel});
		end
	endtask
	task automatic t_data;
		logic [7:0] v;
		for (int i = 0; i < 2; i++) begin
			v = i ? 8'haa : 8'h55;
			load_run('{8'h85, v, 8'h04, 8'h02});
			chk("data out", v, data_out);
		end
	endtask
	task automatic t_loop;
		load_run('{8'h87, 8'hfd, 8'h03, 8'h08, 8'h85, 8'h11, 8'h04, 8'h06,
			8'h03, 8'h0e, 8'h85, 8'h22, 8'h04, 8'h0c, 8'h85, 8'h33,
			8'h04, 8'h10});
		chk("loop result", 8'h22, data_out);
	endtask
	task automatic t_xfer(input logic [3:0] d, input logic [7:0] sw);
		ack_delay = d;
		switch_value = sw;
		seen_addr = 8'h00;
		seen_baud = 8'h00;
		grants = 0;
		// leading byte is an unknown opcode: must not eat the 86
		load_run('{8'h00, 8'h86, 8'hf0, 8'h10, 8'h04, 8'h04});
		chk("address out", 8'hf0, seen_addr);
		chk("baud byte", sw, seen_baud);
		chk("grants", 8'h01, 8'(grants));
	endtask
	task automatic t_clear;
		switch_value = 8'h00;
		// slow ack keeps the request pending when the clear lands
		ack_delay = 4'hf;
		load('{8'h10, 8'h02, 8'h00});
		cmd(CMD_EXECUTE, 8'h00);
		idle(8);
		chk("busy running", 8'h01, {7'h0, exec_busy});
		chk("switch busy bit", 8'h20, switch_rd_data);
		chk("request held", 8'h00, {7'h0, bus.bus_request_n});
		sync_clear = 1'b1;
		idle(1);
		sync_clear = 1'b0;
		idle(1);
		chk("busy cleared", 8'h00, {7'h0, exec_busy});
		chk("request cleared", 8'h01, {7'h0, bus.bus_request_n});
	endtask

	initial begin
		resetn = 1'b0;
		sync_clear = 1'b0;
		host_cmd_valid = 1'b0;
		host_cmd = '0;
		switch_value = 8'hff;
		ack_delay = 4'h0;
		idle(2);
		resetn = 1'b1;
		idle(2);
		chk("switch idle", 8'hdf, switch_rd_data);
		t_psel();
		t_data();
		t_loop();
		t_xfer(4'h0, 8'h18);
		t_xfer(4'h5, 8'h08);
		t_clear();
		complete_run();
	end
endmodule // testbench
